// [src/legacy_timer_defs.svh]
`ifndef LEGACY_TIMER_DEFS_SVH
`define LEGACY_TIMER_DEFS_SVH

// Register byte addresses
`define LT_ADDR_FIRST_LOW 8'h00
`define LT_ADDR_FIRST_HIGH 8'h04
`define LT_ADDR_SECOND_LOW 8'h08
`define LT_ADDR_SECOND_HIGH 8'h0C
`define LT_ADDR_CONTROL 8'h10
`define LT_ADDR_MODE 8'h14
`define LT_ADDR_CLOCK 8'h18
`define LT_ADDR_GATE_CFG 8'h1C
`define LT_ADDR_IRQ_EN 8'h20

// Control/status fields, timer n at these base positions
`define LT_CTL_RUN0 4
`define LT_CTL_OVF0 5
`define LT_CTL_RUN1 6
`define LT_CTL_OVF1 7

// Mode register: four bits per timer, mode at +0, count select at +2, gate at +3
`define LT_MODE_STRIDE 4
`define LT_MODE_SEL 0
`define LT_MODE_CT 2
`define LT_MODE_GATE 3

// Clock control fields
`define LT_CLK_SCALE_LSB 0
`define LT_CLK_SRC0 3
`define LT_CLK_SRC1 4

// Gate polarity fields
`define LT_GATE_POL0 3
`define LT_GATE_POL1 7

// Interrupt enable fields
`define LT_IE_T0 1
`define LT_IE_T1 3

// Count wrap points
`define LT_TOP_13 13'h1FFF
`define LT_TOP_16 16'hFFFF
`define LT_TOP_8 8'hFF

// Reset values
`define LT_RST_BYTE 8'h00

// Prescaler table defaults
`define LT_DIV_CODE0 8'h02
`define LT_DIV_CODE1 8'h04
`define LT_DIV_CODE2 8'h08
`define LT_DIV_CODE3 8'h10

`endif

// [src/legacy_timer_pkg.sv]
package legacy_timer_pkg;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_8BIT_RELOAD = 2'h2,
        MODE_HALTED = 2'h3
    } timer_mode_t;

    typedef enum logic [1:0] {
        APB_IDLE = 2'h1,
        APB_ACK = 2'h2
    } apb_phase_t;

    typedef struct packed {
        apb_phase_t phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0][7:0] lo;
        logic [1:0][7:0] hi;
        logic [1:0] run;
        logic [1:0] ovf;
        logic [7:0] mode_cfg;
        logic [7:0] clk_cfg;
        logic [7:0] gate_cfg;
        logic [7:0] irq_en;
        logic [1:0] irq;
    } core_state_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] stable;
        logic [1:0] fall;
        logic [1:0] gate;
    } sync_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } scale_state_t;

endpackage

// [src/timer_source_if.sv]
`timescale 1ns/1ps
interface timer_source_if;
    logic [1:0] evt_fall;
    logic [1:0] gate_lvl;
    logic pre_tick;
    logic [1:0] scale;

    modport edge_src (output evt_fall, output gate_lvl);
    modport scale_src (input scale, output pre_tick);
    modport core (input evt_fall, input gate_lvl, input pre_tick, output scale);
endinterface

// [src/pin_event_sync.sv]
`timescale 1ns/1ps
module pin_event_sync
    import legacy_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] event_pins,
    input wire logic [1:0] gate_pins,
    timer_source_if.edge_src src
);
    sync_state_t st_reg;
    sync_state_t st_next;
    logic [3:0] raw;

    assign raw = {gate_pins, event_pins};

    always_comb begin
        st_next = st_reg;
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // A level counts only once two stages agree, filtering single-cycle glitches
        for (int i = 0; i < 4; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.stable[i] = st_reg.s3[i];
            end
        end
        for (int i = 0; i < 2; i++) begin
            st_next.fall[i] = st_reg.stable[i] && (st_reg.s2[i] == st_reg.s3[i]) && !st_reg.s3[i];
        end
        st_next.gate = st_next.stable[3:2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign src.evt_fall = st_reg.fall;
    assign src.gate_lvl = st_reg.gate;
endmodule // pin_event_sync

// [src/clock_prescaler.sv]
`timescale 1ns/1ps
`include "legacy_timer_defs.svh"
module clock_prescaler
    import legacy_timer_pkg::*;
#(
    parameter logic [7:0] DIV_CODE0 = `LT_DIV_CODE0,
    parameter logic [7:0] DIV_CODE1 = `LT_DIV_CODE1,
    parameter logic [7:0] DIV_CODE2 = `LT_DIV_CODE2,
    parameter logic [7:0] DIV_CODE3 = `LT_DIV_CODE3
) (
    input wire logic pclk,
    input wire logic presetn,
    timer_source_if.scale_src src
);
    scale_state_t st_reg;
    scale_state_t st_next;

    function automatic logic [7:0] div_of(input logic [1:0] code);
        case (code)
            2'h0: div_of = DIV_CODE0;
            2'h1: div_of = DIV_CODE1;
            2'h2: div_of = DIV_CODE2;
            default: div_of = DIV_CODE3;
        endcase
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        // Table lookup keeps divider ratios swappable per build
        if (st_reg.cnt + 8'h01 >= div_of(src.scale)) begin
            st_next.cnt = 8'h00;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign src.pre_tick = st_reg.tick;
endmodule // clock_prescaler

// [src/dual_legacy_counter_timer.sv]
`timescale 1ns/1ps
`include "legacy_timer_defs.svh"
module dual_legacy_counter_timer
    import legacy_timer_pkg::*;
#(
    parameter logic [7:0] DIV_CODE0 = `LT_DIV_CODE0,
    parameter logic [7:0] DIV_CODE1 = `LT_DIV_CODE1,
    parameter logic [7:0] DIV_CODE2 = `LT_DIV_CODE2,
    parameter logic [7:0] DIV_CODE3 = `LT_DIV_CODE3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_event_pin,
    input wire logic second_event_pin,
    input wire logic first_gate_input,
    input wire logic second_gate_input,
    output logic first_timer_irq,
    output logic second_timer_irq
);
    core_state_t st_reg;
    core_state_t st_next;

    timer_source_if src ();

    pin_event_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .event_pins({second_event_pin, first_event_pin}),
        .gate_pins({second_gate_input, first_gate_input}),
        .src(src.edge_src)
    );

    clock_prescaler #(
        .DIV_CODE0(DIV_CODE0),
        .DIV_CODE1(DIV_CODE1),
        .DIV_CODE2(DIV_CODE2),
        .DIV_CODE3(DIV_CODE3)
    ) u_scale (
        .pclk(pclk),
        .presetn(presetn),
        .src(src.scale_src)
    );

    assign src.scale = st_reg.clk_cfg[`LT_CLK_SCALE_LSB +: 2];

    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            `LT_ADDR_FIRST_LOW,
            `LT_ADDR_FIRST_HIGH,
            `LT_ADDR_SECOND_LOW,
            `LT_ADDR_SECOND_HIGH,
            `LT_ADDR_CONTROL,
            `LT_ADDR_MODE,
            `LT_ADDR_CLOCK,
            `LT_ADDR_GATE_CFG,
            `LT_ADDR_IRQ_EN: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] control_byte(input core_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[`LT_CTL_RUN0] = s.run[0];
        v[`LT_CTL_OVF0] = s.ovf[0];
        v[`LT_CTL_RUN1] = s.run[1];
        v[`LT_CTL_OVF1] = s.ovf[1];
        control_byte = v;
    endfunction

    function automatic logic [7:0] read_byte(input core_state_t s, input logic [7:0] a);
        case (a)
            `LT_ADDR_FIRST_LOW: read_byte = s.lo[0];
            `LT_ADDR_FIRST_HIGH: read_byte = s.hi[0];
            `LT_ADDR_SECOND_LOW: read_byte = s.lo[1];
            `LT_ADDR_SECOND_HIGH: read_byte = s.hi[1];
            `LT_ADDR_CONTROL: read_byte = control_byte(s);
            `LT_ADDR_MODE: read_byte = s.mode_cfg;
            `LT_ADDR_CLOCK: read_byte = s.clk_cfg;
            `LT_ADDR_GATE_CFG: read_byte = s.gate_cfg;
            `LT_ADDR_IRQ_EN: read_byte = s.irq_en;
            default: read_byte = 8'h00;
        endcase
    endfunction

    function automatic logic gate_pol(input core_state_t s, input int t);
        gate_pol = (t == 0) ? s.gate_cfg[`LT_GATE_POL0] : s.gate_cfg[`LT_GATE_POL1];
    endfunction

    function automatic logic clk_src_bit(input core_state_t s, input int t);
        clk_src_bit = (t == 0) ? s.clk_cfg[`LT_CLK_SRC0] : s.clk_cfg[`LT_CLK_SRC1];
    endfunction

    function automatic logic irq_en_bit(input core_state_t s, input int t);
        irq_en_bit = (t == 0) ? s.irq_en[`LT_IE_T0] : s.irq_en[`LT_IE_T1];
    endfunction

    logic [1:0] tick;
    logic [1:0] enable;
    logic [1:0] wrap;
    logic [1:0] set_ovf;
    logic [1:0][7:0] lo_cnt;
    logic [1:0][7:0] hi_cnt;
    logic do_write;
    logic [7:0] wbyte;

    // Count sources and enables, identical per timer
    always_comb begin
        tick = 2'h0;
        enable = 2'h0;
        for (int t = 0; t < 2; t++) begin
            logic [3:0] cfg;
            logic gate_open;
            cfg = st_reg.mode_cfg[t * `LT_MODE_STRIDE +: 4];
            if (cfg[`LT_MODE_CT]) begin
                tick[t] = src.evt_fall[t];
            end else if (clk_src_bit(st_reg, t)) begin
                tick[t] = 1'b1;
            end else begin
                tick[t] = src.pre_tick;
            end
            // Gate input two uses its own polarity bit
            gate_open = (src.gate_lvl[t] == gate_pol(st_reg, t));
            enable[t] = st_reg.run[t] && (!cfg[`LT_MODE_GATE] || gate_open);
        end
    end

    // Count step per mode
    always_comb begin
        wrap = 2'h0;
        lo_cnt = st_reg.lo;
        hi_cnt = st_reg.hi;
        for (int t = 0; t < 2; t++) begin
            logic [12:0] c13;
            logic [15:0] c16;
            c13 = {st_reg.hi[t], st_reg.lo[t][4:0]};
            c16 = {st_reg.hi[t], st_reg.lo[t]};
            if (tick[t] && enable[t]) begin
                case (timer_mode_t'(st_reg.mode_cfg[t * `LT_MODE_STRIDE +: 2]))
                    MODE_13BIT: begin
                        wrap[t] = (c13 == `LT_TOP_13);
                        c13 = c13 + 13'h0001;
                        // Upper low-byte bits just hold their old value
                        lo_cnt[t] = {st_reg.lo[t][7:5], c13[4:0]};
                        hi_cnt[t] = c13[12:5];
                    end
                    MODE_16BIT: begin
                        wrap[t] = (c16 == `LT_TOP_16);
                        c16 = c16 + 16'h0001;
                        lo_cnt[t] = c16[7:0];
                        hi_cnt[t] = c16[15:8];
                    end
                    MODE_8BIT_RELOAD: begin
                        wrap[t] = (st_reg.lo[t] == `LT_TOP_8);
                        lo_cnt[t] = wrap[t] ? st_reg.hi[t] : st_reg.lo[t] + 8'h01;
                        hi_cnt[t] = st_reg.hi[t];
                    end
                    MODE_HALTED: begin
                        // Split mode not built; timer simply holds
                        wrap[t] = 1'b0;
                    end
                    default: begin
                        wrap[t] = 1'b0;
                    end
                endcase
            end
        end
        set_ovf = wrap;
    end

    assign do_write = (st_reg.phase == APB_ACK) && psel && penable && pwrite && addr_mapped(paddr);
    assign wbyte = pwdata[7:0];

    always_comb begin
        st_next = st_reg;
        // Counting never clears on run, only steps from what is held
        st_next.lo = lo_cnt;
        st_next.hi = hi_cnt;
        st_next.ovf = st_reg.ovf | set_ovf;

        case (st_reg.phase)
            APB_IDLE: begin
                if (psel && !penable) begin
                    // Read data is captured in setup, one cycle before the sample edge
                    st_next.prdata = {24'h000000, read_byte(st_reg, paddr)};
                    st_next.pslverr = !addr_mapped(paddr);
                    st_next.pready = 1'b1;
                    st_next.phase = APB_ACK;
                end
            end
            APB_ACK: begin
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.phase = APB_IDLE;
            end
            default: begin
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.phase = APB_IDLE;
            end
        endcase

        if (do_write) begin
            case (paddr)
                `LT_ADDR_FIRST_LOW: st_next.lo[0] = wbyte;
                `LT_ADDR_FIRST_HIGH: st_next.hi[0] = wbyte;
                `LT_ADDR_SECOND_LOW: st_next.lo[1] = wbyte;
                `LT_ADDR_SECOND_HIGH: st_next.hi[1] = wbyte;
                `LT_ADDR_CONTROL: begin
                    st_next.run[0] = wbyte[`LT_CTL_RUN0];
                    st_next.run[1] = wbyte[`LT_CTL_RUN1];
                    // A hardware set in the same cycle beats a software clear
                    st_next.ovf[0] = wbyte[`LT_CTL_OVF0] | set_ovf[0];
                    st_next.ovf[1] = wbyte[`LT_CTL_OVF1] | set_ovf[1];
                end
                `LT_ADDR_MODE: st_next.mode_cfg = wbyte;
                `LT_ADDR_CLOCK: st_next.clk_cfg = wbyte;
                `LT_ADDR_GATE_CFG: st_next.gate_cfg = wbyte;
                `LT_ADDR_IRQ_EN: st_next.irq_en = wbyte;
                default: st_next.irq_en = st_reg.irq_en;
            endcase
        end

        for (int t = 0; t < 2; t++) begin
            st_next.irq[t] = st_next.ovf[t] && irq_en_bit(st_next, t);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.phase <= APB_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign first_timer_irq = st_reg.irq[0];
    assign second_timer_irq = st_reg.irq[1];
endmodule // dual_legacy_counter_timer

// [verification/legacy_timer_asserts.sv]
`timescale 1ns/1ps
`include "legacy_timer_defs.svh"
module legacy_timer_asserts
    import legacy_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic first_event_pin,
    input wire logic second_event_pin,
    input wire logic first_gate_input,
    input wire logic second_gate_input,
    input wire logic first_timer_irq,
    input wire logic second_timer_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_w;
    assign acc_w = psel && penable && pwrite && pready;

    AST_ACK_AFTER_SETUP: assert property (psel && !penable |=> pready) else $error("no ack");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
    AST_READY_CAUSE: assert property ($rose(pready) |-> $past(psel && !penable)) else $error("stray ready");
    AST_RDATA_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
    AST_UNMAPPED: assert property (pready && paddr > `LT_ADDR_IRQ_EN |-> pslverr && prdata == 32'h0)
        else $error("unmapped ok");
    AST_CTL_RSVD: assert property (pready && !pwrite && paddr == `LT_ADDR_CONTROL |-> prdata[3:0] == 4'h0)
        else $error("ctl low bits");
    AST_IRQ0_OFF: assert property (acc_w && paddr == `LT_ADDR_IRQ_EN && !pwdata[`LT_IE_T0]
        |=> !first_timer_irq) else $error("irq0 not masked");
    AST_IRQ1_OFF: assert property (acc_w && paddr == `LT_ADDR_IRQ_EN && !pwdata[`LT_IE_T1]
        |=> !second_timer_irq) else $error("irq1 not masked");
    AST_IRQ_FALL: assert property ($fell(first_timer_irq) || $fell(second_timer_irq)
        |-> $past(acc_w && (paddr == `LT_ADDR_CONTROL || paddr == `LT_ADDR_IRQ_EN))) else $error("irq drop");

    cover property (acc_w && paddr == `LT_ADDR_MODE);
    cover property ($rose(first_timer_irq));
    cover property ($rose(second_timer_irq));
    cover property (pready && pslverr);
endmodule // legacy_timer_asserts

bind dual_legacy_counter_timer legacy_timer_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_event_pin(first_event_pin), .second_event_pin(second_event_pin),
    .first_gate_input(first_gate_input), .second_gate_input(second_gate_input),
    .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq));

// [verification/pin_source.sv]
`timescale 1ns/1ps
module pin_source (
    input wire logic pclk,
    output logic [1:0] evt,
    output logic [1:0] gate
);
    initial begin
        evt = 2'h3;
        gate = 2'h0;
    end
    // Two clocks per level: fastest legal rate, a quarter of pclk
    task pulses(input int ch, input int n);
        repeat (n) begin
            @(posedge pclk);
            evt[ch] <= 1'h0;
            repeat (2) @(posedge pclk);
            evt[ch] <= 1'h1;
            repeat (1) @(posedge pclk);
        end
        // Let the synchroniser latency drain
        repeat (7) @(posedge pclk);
    endtask
    task set_gate(input int ch, input logic v);
        @(posedge pclk);
        gate[ch] <= v;
        repeat (5) @(posedge pclk);
    endtask
endmodule // pin_source

// [verification/tb.sv]
`timescale 1ns/1ps
`include "legacy_timer_defs.svh"
module tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, first_timer_irq, second_timer_irq;
    logic [1:0] evt, gate;
    int failures = 0;
    int check_count = 0;

    always #12.5 pclk = ~pclk;

    pin_source src (.pclk(pclk), .evt(evt), .gate(gate));
    dual_legacy_counter_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_event_pin(evt[0]), .second_event_pin(evt[1]), .first_gate_input(gate[0]),
        .second_gate_input(gate[1]), .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq));

    task fail(input string m);
        failures++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) fail($sformatf("got %h exp %h", g, x));
    endtask
    task chk_rng(input logic [31:0] g, input int lo, input int hi);
        check_count++;
        if ((g >= lo && g <= hi) !== 1'h1) fail($sformatf("got %h out of range", g));
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n == 50) fail("no pready");
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 8'h00, r, e);
        chk(r, x);
    endtask

    task t_reset;
        logic [31:0] r;
        logic e;
        for (int a = 0; a <= 32; a += 4) rdc(8'(a), 32'h0);
        apb(1'h0, 8'h24, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task t_wrap16;
        wr(`LT_ADDR_MODE, 8'h01);
        wr(`LT_ADDR_CLOCK, 8'h08);
        wr(`LT_ADDR_IRQ_EN, 8'h02);
        wr(`LT_ADDR_FIRST_LOW, 8'hF0);
        wr(`LT_ADDR_FIRST_HIGH, 8'hFF);
        wr(`LT_ADDR_CONTROL, 8'h10);
        repeat (30) @(posedge pclk);
        wr(`LT_ADDR_CONTROL, 8'h20);
        rdc(`LT_ADDR_FIRST_HIGH, 32'h0);
        rdc(`LT_ADDR_CONTROL, 32'h20);
        chk({31'h0, first_timer_irq}, 32'h1);
        wr(`LT_ADDR_IRQ_EN, 8'h00);
        chk({31'h0, first_timer_irq}, 32'h0);
        wr(`LT_ADDR_CONTROL, 8'h00);
    endtask
    task t_evt13;
        logic [31:0] r;
        logic e;
        wr(`LT_ADDR_MODE, 8'h04);
        wr(`LT_ADDR_FIRST_LOW, 8'h1E);
        wr(`LT_ADDR_FIRST_HIGH, 8'hFF);
        wr(`LT_ADDR_CONTROL, 8'h10);
        src.pulses(0, 3);
        apb(1'h0, `LT_ADDR_FIRST_LOW, 8'h00, r, e);
        chk(r & 32'h1F, 32'h01);
        rdc(`LT_ADDR_FIRST_HIGH, 32'h0);
        rdc(`LT_ADDR_CONTROL, 32'h30);
        chk({31'h0, first_timer_irq}, 32'h0);
        wr(`LT_ADDR_CONTROL, 8'h00);
    endtask
    task t_gate;
        wr(`LT_ADDR_MODE, 8'hD0);
        wr(`LT_ADDR_GATE_CFG, 8'h80);
        wr(`LT_ADDR_SECOND_LOW, 8'h00);
        wr(`LT_ADDR_SECOND_HIGH, 8'h00);
        wr(`LT_ADDR_CONTROL, 8'h40);
        src.pulses(1, 2);
        rdc(`LT_ADDR_SECOND_LOW, 32'h0);
        src.set_gate(1, 1'h1);
        src.pulses(1, 2);
        rdc(`LT_ADDR_SECOND_LOW, 32'h2);
        src.set_gate(1, 1'h0);
        wr(`LT_ADDR_CONTROL, 8'h00);
    endtask
    task t_reload;
        wr(`LT_ADDR_MODE, 8'h60);
        wr(`LT_ADDR_IRQ_EN, 8'h08);
        wr(`LT_ADDR_SECOND_LOW, 8'hFE);
        wr(`LT_ADDR_SECOND_HIGH, 8'hA0);
        wr(`LT_ADDR_CONTROL, 8'h40);
        src.pulses(1, 3);
        rdc(`LT_ADDR_SECOND_LOW, 32'hA1);
        rdc(`LT_ADDR_SECOND_HIGH, 32'hA0);
        rdc(`LT_ADDR_CONTROL, 32'hC0);
        chk({31'h0, second_timer_irq}, 32'h1);
        wr(`LT_ADDR_CONTROL, 8'h00);
        chk({31'h0, second_timer_irq}, 32'h0);
        // Halted mode must ignore events even while running
        wr(`LT_ADDR_MODE, 8'h70);
        wr(`LT_ADDR_CONTROL, 8'h40);
        src.pulses(1, 2);
        rdc(`LT_ADDR_SECOND_LOW, 32'hA1);
        wr(`LT_ADDR_CONTROL, 8'h00);
    endtask
    // Prescaler phase is free running, so the count is checked within a window
    task t_scale;
        logic [31:0] r;
        logic e;
        wr(`LT_ADDR_MODE, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(`LT_ADDR_CLOCK, 8'(k));
            wr(`LT_ADDR_FIRST_LOW, 8'h00);
            wr(`LT_ADDR_CONTROL, 8'h10);
            repeat (64) @(posedge pclk);
            wr(`LT_ADDR_CONTROL, 8'h00);
            apb(1'h0, `LT_ADDR_FIRST_LOW, 8'h00, r, e);
            chk_rng(r, 64 / (2 << k) - 1, 70 / (2 << k) + 1);
        end
    endtask

    task test_done;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_wrap16();
        t_evt13();
        t_gate();
        t_reload();
        t_scale();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail("watchdog");
        test_done();
    end
endmodule // tb
